// >>> src/mie_move_exec.sv
// move and indirect-move execution unit with axi4-lite register access
// assumes data memory and file register port on CLK_SYS, read data one cycle after read
`timescale 1ns/1ps
module mie_move_exec
    import mie_pkg::*;
(
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // axi4-lite write
    input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // data memory
    output logic [PTR_W-1:0] MEM_ADDR,
    output logic [DATA_W-1:0] MEM_WDATA,
    output logic MEM_WE,
    output logic MEM_RE,
    input wire logic [DATA_W-1:0] MEM_RDATA,
    // file register
    output logic [FILE_W-1:0] FILE_ADDR,
    output logic [DATA_W-1:0] FILE_WDATA,
    output logic FILE_WE,
    // core state
    output logic [BANK_W-1:0] BANK_SEL,
    output logic [PAGE_W-1:0] PC_HIGH,
    output logic BUSY
);

    mie_state_t state_q;
    logic [15:0] ir_q;
    logic [DATA_W-1:0] acc_q;
    logic zero_q;
    logic [PTR_W-1:0] ptr_q [PTR_N];
    logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [AXI_ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q, rdata_q, rdata_d;
    logic [3:0] wstrb_q;
    logic rd_hit;
    logic wr_go, wr_hit, reg_wr, instr_wr;
    logic [3:0] op;
    logic ptr_idx, is_rel, is_ind, is_load, exec, win_hit, win_idx;
    mie_mode_t mode;
    logic [PTR_W-1:0] sel_ptr, ea, ptr_next;
    logic [FILE_W-1:0] file_sel;

    // write channel capture
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
            waddr_q <= '0;
        end
        else if (S_AXI_AWVALID && awready_q)
        begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            waddr_q <= S_AXI_AWADDR;
        end
        else if (wr_go)
        begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (S_AXI_WVALID && wready_q)
        begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
        end
        else if (wr_go)
        begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign wr_hit = (waddr_q == ADDR_INSTR) || (waddr_q == ADDR_ACC) || (waddr_q == ADDR_BANK)
        || (waddr_q == ADDR_PAGE) || (waddr_q == ADDR_PTR0)
        || (waddr_q == ADDR_PTR0 + PTR_STRIDE) || (waddr_q == ADDR_STATUS);
    assign reg_wr = wr_go && (state_q == ST_IDLE);
    assign instr_wr = reg_wr && (waddr_q == ADDR_INSTR) && (wstrb_q[1:0] == 2'b11);

    // write response
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (bvalid_q && S_AXI_BREADY)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // read mux
    always_comb
    begin
        rdata_d = '0;
        rd_hit = 1'b1;
        if (S_AXI_ARADDR == ADDR_INSTR)
            rdata_d[15:0] = ir_q;
        else if (S_AXI_ARADDR == ADDR_ACC)
            rdata_d[DATA_W-1:0] = acc_q;
        else if (S_AXI_ARADDR == ADDR_BANK)
            rdata_d[BANK_W-1:0] = BANK_SEL;
        else if (S_AXI_ARADDR == ADDR_PAGE)
            rdata_d[PAGE_W-1:0] = PC_HIGH;
        else if (S_AXI_ARADDR == ADDR_PTR0)
            rdata_d[PTR_W-1:0] = ptr_q[0];
        else if (S_AXI_ARADDR == ADDR_PTR0 + PTR_STRIDE)
            rdata_d[PTR_W-1:0] = ptr_q[1];
        else if (S_AXI_ARADDR == ADDR_STATUS)
        begin
            rdata_d[STATUS_Z_BIT] = zero_q;
            rdata_d[STATUS_BUSY_BIT] = (state_q != ST_IDLE);
        end
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rdata_d;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (rvalid_q && S_AXI_RREADY)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // decode
    assign op = ir_q[OP_MSB:OP_LSB];
    assign ptr_idx = ir_q[PTR_SEL_BIT];
    assign mode = mie_mode_t'(ir_q[MODE_MSB:MODE_LSB]);
    assign is_rel = (op == OP_LOAD_REL) || (op == OP_STORE_REL);
    assign is_load = (op == OP_LOAD_IND) || (op == OP_LOAD_REL);
    assign is_ind = is_rel || (op == OP_LOAD_IND) || (op == OP_STORE_IND);
    assign exec = (state_q == ST_EXEC);
    assign sel_ptr = ptr_q[ptr_idx];
    assign file_sel = ir_q[FILE_MSB:0];
    assign win_hit = (op == OP_ACC_FILE) && ((file_sel == WIN0_ADDR) || (file_sel == WIN1_ADDR));
    assign win_idx = (file_sel == WIN1_ADDR);

    mie_ea_calc u_ea (
        .ptr(sel_ptr),
        .mode(mode),
        .rel(is_rel),
        .offset(ir_q[OFF_MSB:OFF_LSB]),
        .ea(ea),
        .ptr_next(ptr_next)
    );

    // sequencer
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_q <= ST_IDLE;
            ir_q <= '0;
            BUSY <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (instr_wr)
                    begin
                        ir_q <= wdata_q[15:0];
                        state_q <= ST_EXEC;
                        BUSY <= 1'b1;
                    end
                ST_EXEC:
                    if (is_ind && is_load)
                        state_q <= ST_WAIT;
                    else
                    begin
                        state_q <= ST_IDLE;
                        BUSY <= 1'b0;
                    end
                ST_WAIT:
                    state_q <= ST_CAP;
                ST_CAP:
                begin
                    state_q <= ST_IDLE;
                    BUSY <= 1'b0;
                end
            endcase
        end
    end

    // data memory port
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            MEM_ADDR <= '0;
            MEM_WDATA <= '0;
            MEM_WE <= 1'b0;
            MEM_RE <= 1'b0;
        end
        else
        begin
            MEM_WE <= 1'b0;
            MEM_RE <= 1'b0;
            if (exec && is_ind)
            begin
                MEM_ADDR <= ea;
                MEM_WDATA <= acc_q;
                MEM_WE <= !is_load;
                MEM_RE <= is_load;
            end
            else if (exec && win_hit)
            begin
                MEM_ADDR <= ptr_q[win_idx];
                MEM_WDATA <= acc_q;
                MEM_WE <= 1'b1;
            end
        end
    end

    // file register port
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            FILE_ADDR <= '0;
            FILE_WDATA <= '0;
            FILE_WE <= 1'b0;
        end
        else
        begin
            FILE_WE <= 1'b0;
            if (exec && (op == OP_ACC_FILE) && !win_hit)
            begin
                FILE_ADDR <= file_sel;
                FILE_WDATA <= acc_q;
                FILE_WE <= 1'b1;
            end
        end
    end

    // file pointers
    for (genvar i = 0; i < PTR_N; i++)
    begin : g_ptr
        always_ff @(posedge CLK_SYS)
        begin
            if (RST)
                ptr_q[i] <= PTR_RST;
            else if (exec && is_ind && (ptr_idx == 1'(i)))
                ptr_q[i] <= ptr_next;
            else if (reg_wr && (waddr_q == ADDR_PTR0 + PTR_STRIDE * 8'(i)))
            begin
                if (wstrb_q[0])
                    ptr_q[i][7:0] <= wdata_q[7:0];
                if (wstrb_q[1])
                    ptr_q[i][15:8] <= wdata_q[15:8];
            end
        end
    end

    // accumulator and zero flag
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            acc_q <= ACC_RST;
            zero_q <= 1'b0;
        end
        else if (state_q == ST_CAP)
        begin
            acc_q <= MEM_RDATA;
            zero_q <= (MEM_RDATA == '0);
        end
        else if (exec && (op == OP_ACC_LIT))
            acc_q <= ir_q[LIT_MSB:0];
        else if (reg_wr && (waddr_q == ADDR_ACC) && wstrb_q[0])
            acc_q <= wdata_q[DATA_W-1:0];
    end

    // bank select and page latch
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            BANK_SEL <= BANK_RST;
            PC_HIGH <= PAGE_RST;
        end
        else if (exec && (op == OP_BANK_LIT))
            BANK_SEL <= ir_q[BANK_MSB:0];
        else if (exec && (op == OP_PAGE_LIT))
            PC_HIGH <= ir_q[PAGE_MSB:0];
        else if (reg_wr && wstrb_q[0] && (waddr_q == ADDR_BANK))
            BANK_SEL <= wdata_q[BANK_W-1:0];
        else if (reg_wr && wstrb_q[0] && (waddr_q == ADDR_PAGE))
            PC_HIGH <= wdata_q[PAGE_W-1:0];
    end

    // checks
    a_load_capture: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && is_load |-> ##2 (state_q == ST_CAP) ##1
        (acc_q == $past(MEM_RDATA) && zero_q == ($past(MEM_RDATA) == '0)))
        else $error("indirect load byte or zero flag wrong");
    a_store_write: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_load |=> MEM_WE && !MEM_RE
        && MEM_WDATA == $past(acc_q) && MEM_ADDR == $past(ea))
        else $error("indirect store not issued");
    a_window_redirect: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && win_hit |=> MEM_WE && !FILE_WE && MEM_ADDR == $past(ptr_q[win_idx]))
        else $error("window access not redirected");
    a_pre_inc: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_rel && mode == MIE_PRE_INC |=>
        MEM_ADDR == 16'($past(sel_ptr) + STEP_ONE) && ptr_q[$past(ptr_idx)] == MEM_ADDR)
        else $error("preincrement address wrong");
    a_pre_dec: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_rel && mode == MIE_PRE_DEC |=>
        MEM_ADDR == 16'($past(sel_ptr) - STEP_ONE) && ptr_q[$past(ptr_idx)] == MEM_ADDR)
        else $error("predecrement address wrong");
    a_rel_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_rel |=> $stable(ptr_q[0]) && $stable(ptr_q[1])
        && MEM_ADDR == 16'($past(sel_ptr) + {{10{$past(ir_q[OFF_MSB])}}, $past(ir_q[5:0])}))
        else $error("relative access wrong");
    a_post_step: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_rel && mode == MIE_POST_INC |=>
        MEM_ADDR == $past(sel_ptr) && ptr_q[$past(ptr_idx)] == 16'(MEM_ADDR + STEP_ONE))
        else $error("postincrement wrong");
    a_post_dec: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_rel && mode == MIE_POST_DEC |=>
        MEM_ADDR == $past(sel_ptr) && ptr_q[$past(ptr_idx)] == 16'(MEM_ADDR - STEP_ONE))
        else $error("postdecrement wrong");
    a_ptr_wrap: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && is_ind && !is_rel && mode == MIE_PRE_INC && sel_ptr == 16'hFFFF |=>
        MEM_ADDR == 16'h0000)
        else $error("pointer did not wrap");
    a_flag_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && !(is_ind && is_load) |=> $stable(zero_q))
        else $error("status flag changed");
    a_bank_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && op == OP_BANK_LIT |=> BANK_SEL == $past(ir_q[BANK_MSB:0]))
        else $error("bank literal not loaded");
    a_page_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && op == OP_PAGE_LIT |=> PC_HIGH == $past(ir_q[PAGE_MSB:0]))
        else $error("page literal not loaded");
    a_acc_lit: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && op == OP_ACC_LIT |=> acc_q == $past(ir_q[LIT_MSB:0]) && !BUSY)
        else $error("accumulator literal not loaded");
    a_file_store: assert property (@(posedge CLK_SYS) disable iff (RST)
        exec && op == OP_ACC_FILE && !win_hit |=> FILE_WE && !MEM_WE
        && FILE_ADDR == $past(file_sel) && FILE_WDATA == $past(acc_q))
        else $error("file store wrong");

endmodule

// >>> src/mie_pkg.sv
// constants and types for the move / indirect execution unit
// assumes one clock domain shared with the core data memory and register file
// Behaviour
// - indirect load copies byte, updates zero flag
// - indirect store writes accumulator at effective address
// - window locations redirect to their file pointer
// - preincrement: add one, use, keep
// - predecrement: subtract one, use, keep
// - relative offset: pointer plus offset, unchanged
// - post modes: access, then step pointer
// - mode field 00,01,10,11 = pre+,pre-,post+,post-
// - pointers wrap modulo 65536
// - bank literal loads 5-bit field, flags kept
// - page literal loads 7-bit latch, flags kept
// - accumulator literal loads 8 bits, flags kept
// - store to file at 7-bit address
// - pointer stepping never touches status flags
package mie_pkg;

    // register map, byte addresses
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_BANK = 8'h08;
    localparam logic [7:0] ADDR_PAGE = 8'h0C;
    localparam logic [7:0] ADDR_PTR0 = 8'h10;
    localparam logic [7:0] PTR_STRIDE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // widths
    localparam int PTR_W = 16;
    localparam int DATA_W = 8;
    localparam int BANK_W = 5;
    localparam int PAGE_W = 7;
    localparam int FILE_W = 7;
    localparam int OFF_W = 6;
    localparam int PTR_N = 2;

    // instruction word fields
    localparam int OP_MSB = 15;
    localparam int OP_LSB = 12;
    localparam int PTR_SEL_BIT = 8;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;
    localparam int OFF_MSB = 5;
    localparam int OFF_LSB = 0;
    localparam int LIT_MSB = 7;
    localparam int BANK_MSB = 4;
    localparam int PAGE_MSB = 6;
    localparam int FILE_MSB = 6;
    localparam int STATUS_Z_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;

    // opcodes
    localparam logic [3:0] OP_LOAD_IND = 4'h1;
    localparam logic [3:0] OP_LOAD_REL = 4'h2;
    localparam logic [3:0] OP_STORE_IND = 4'h3;
    localparam logic [3:0] OP_STORE_REL = 4'h4;
    localparam logic [3:0] OP_BANK_LIT = 4'h5;
    localparam logic [3:0] OP_PAGE_LIT = 4'h6;
    localparam logic [3:0] OP_ACC_LIT = 4'h7;
    localparam logic [3:0] OP_ACC_FILE = 4'h8;

    // indirect window file addresses
    localparam logic [6:0] WIN0_ADDR = 7'h00;
    localparam logic [6:0] WIN1_ADDR = 7'h01;

    // reset values and pointer step
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] BANK_RST = 5'h00;
    localparam logic [6:0] PAGE_RST = 7'h00;
    localparam logic [15:0] STEP_ONE = 16'h0001;

    typedef enum logic [1:0] {
        MIE_PRE_INC = 2'b00,
        MIE_PRE_DEC = 2'b01,
        MIE_POST_INC = 2'b10,
        MIE_POST_DEC = 2'b11
    } mie_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b10,
        ST_CAP = 2'b11
    } mie_state_t;

endpackage

// >>> src/mie_ea_calc.sv
// effective address and next pointer value for indirect moves
// assumes pure combinational use inside the execution unit
`timescale 1ns/1ps
module mie_ea_calc
    import mie_pkg::*;
(
    // operands
    input wire logic [PTR_W-1:0] ptr,
    input mie_mode_t mode,
    input wire logic rel,
    input wire logic [OFF_W-1:0] offset,
    // results
    output logic [PTR_W-1:0] ea,
    output logic [PTR_W-1:0] ptr_next
);

    logic [PTR_W-1:0] ptr_inc;
    logic [PTR_W-1:0] ptr_dec;
    logic [PTR_W-1:0] off_ext;

    always_comb
    begin
        ptr_inc = ptr + STEP_ONE;
        ptr_dec = ptr - STEP_ONE;
        off_ext = {{(PTR_W-OFF_W){offset[OFF_W-1]}}, offset};
        if (rel)
        begin
            ea = ptr + off_ext;
            ptr_next = ptr;
        end
        else
        begin
            unique case (mode)
                MIE_PRE_INC:
                begin
                    ea = ptr_inc;
                    ptr_next = ptr_inc;
                end
                MIE_PRE_DEC:
                begin
                    ea = ptr_dec;
                    ptr_next = ptr_dec;
                end
                MIE_POST_INC:
                begin
                    ea = ptr;
                    ptr_next = ptr_inc;
                end
                MIE_POST_DEC:
                begin
                    ea = ptr;
                    ptr_next = ptr_dec;
                end
            endcase
        end
    end

endmodule

// >>> test/mie_mem_model.sv
// behavioural data memory and file register bank for the bench
// assumes registered read: data valid in the cycle after a read strobe
`timescale 1ns/1ps
module mie_mem_model
    import mie_pkg::*;
(
    // clock
    input wire logic clk,
    // data memory
    input wire logic [PTR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [DATA_W-1:0] rdata,
    // file register
    input wire logic [FILE_W-1:0] faddr,
    input wire logic [DATA_W-1:0] fwdata,
    input wire logic fwe
);
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] fregs [0:127];
    logic [DATA_W-1:0] last_q = 8'h00;
    logic vld_q = 1'h0;
    // outside the answer cycle the bus shows a garbled value
    assign rdata = vld_q ? last_q : ~last_q;
    always @(posedge clk)
    begin
        vld_q <= re;
        if (re)
            last_q <= mem[addr];
        if (we)
            mem[addr] <= wdata;
        if (fwe)
            fregs[faddr] <= fwdata;
    end
endmodule

// >>> test/mie_move_exec_tb.sv
// self-checking bench for the move / indirect execution unit
// assumes mie_mem_model stands in for data memory and file registers
`timescale 1ns/1ps
module mie_move_exec_tb;
    import mie_pkg::*;
    localparam logic [7:0] PTR1 = ADDR_PTR0 + PTR_STRIDE;
    logic clk = 1'h0, rst = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, mre, mwe, fwe, busy;
    logic [1:0] bresp, rresp;
    logic [1:0] bresp_seen = 2'b00;
    logic [31:0] rdata;
    logic [15:0] maddr;
    logic [7:0] mwdata, mrdata, fwdata;
    logic [6:0] faddr, pch;
    logic [4:0] bank;
    int fails = 0, checks = 0;

    mie_move_exec i_dut (
        .CLK_SYS(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(1'h1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'h1),
        .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_WE(mwe), .MEM_RE(mre),
        .MEM_RDATA(mrdata), .FILE_ADDR(faddr), .FILE_WDATA(fwdata), .FILE_WE(fwe),
        .BANK_SEL(bank), .PC_HIGH(pch), .BUSY(busy)
    );

    mie_mem_model i_mem (
        .clk(clk), .addr(maddr), .wdata(mwdata), .we(mwe), .re(mre), .rdata(mrdata),
        .faddr(faddr), .fwdata(fwdata), .fwe(fwe)
    );

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the model's write lands one edge before the check resumes, at the edge ex returns on
    task automatic mchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        chk(32'(i_mem.mem[a]), 32'(exp));
    endtask

    // address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        #1;
        while (awvalid || wvalid)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            #1;
        end
        do @(posedge clk); while (!bvalid);
        bresp_seen = bresp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        chk(rdata, exp);
        chk(32'(rresp), 32'(rs));
    endtask

    // launch one instruction and wait until it retires
    task automatic ex(input logic [3:0] op, input logic sel, input logic [7:0] low);
        axw(ADDR_INSTR, {16'h0000, op, 3'h0, sel, low});
        do @(posedge clk); while (busy);
    endtask

    task automatic t_reset();
        for (int a = 4; a <= 24; a += 4)
            rd_chk(8'(a), 32'h0000_0000, RESP_OKAY);
        rd_chk(8'h1C, 32'h0000_0000, RESP_DECERR);
        rd_chk(8'h02, 32'h0000_0000, RESP_DECERR);
        axw(8'h1C, 32'h0000_00FF);
        chk(32'(bresp_seen), 32'(RESP_DECERR));
        chk(32'(bank), 32'h0000_0000);
        chk(32'(pch), 32'h0000_0000);
    endtask

    task automatic t_loads();
        i_mem.mem[16'h1234] = 8'h00;
        i_mem.mem[16'h1235] = 8'h81;
        axw(ADDR_PTR0, 32'h0000_1235);
        chk(32'(bresp_seen), 32'(RESP_OKAY));
        ex(OP_LOAD_IND, 1'h0, 8'(MIE_POST_DEC));
        rd_chk(ADDR_ACC, 32'h0000_0081, RESP_OKAY);
        rd_chk(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
        rd_chk(ADDR_PTR0, 32'h0000_1234, RESP_OKAY);
        ex(OP_LOAD_IND, 1'h0, 8'(MIE_POST_INC));
        rd_chk(ADDR_ACC, 32'h0000_0000, RESP_OKAY);
        rd_chk(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
        rd_chk(ADDR_PTR0, 32'h0000_1235, RESP_OKAY);
    endtask

    task automatic t_literals();
        ex(OP_ACC_LIT, 1'h0, 8'hA5);
        rd_chk(ADDR_ACC, 32'h0000_00A5, RESP_OKAY);
        ex(OP_BANK_LIT, 1'h0, 8'h1F);
        chk(32'(bank), 32'h0000_001F);
        ex(OP_PAGE_LIT, 1'h0, 8'h7F);
        chk(32'(pch), 32'h0000_007F);
        rd_chk(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
    endtask

    task automatic t_stores();
        axw(ADDR_PTR0, 32'h0000_FFFF);
        axw(PTR1, 32'h0000_0000);
        ex(OP_STORE_IND, 1'h0, 8'(MIE_PRE_INC));
        mchk(16'h0000, 8'hA5);
        rd_chk(ADDR_PTR0, 32'h0000_0000, RESP_OKAY);
        ex(OP_STORE_IND, 1'h1, 8'(MIE_PRE_DEC));
        mchk(16'hFFFF, 8'hA5);
        rd_chk(PTR1, 32'h0000_FFFF, RESP_OKAY);
        rd_chk(ADDR_PTR0, 32'h0000_0000, RESP_OKAY);
        rd_chk(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
    endtask

    task automatic t_rel();
        axw(PTR1, 32'h0000_0005);
        ex(OP_STORE_REL, 1'h1, 8'h20);
        mchk(16'hFFE5, 8'hA5);
        i_mem.mem[16'h0024] = 8'h5A;
        ex(OP_LOAD_REL, 1'h1, 8'h1F);
        rd_chk(ADDR_ACC, 32'h0000_005A, RESP_OKAY);
        rd_chk(PTR1, 32'h0000_0005, RESP_OKAY);
    endtask

    task automatic t_file();
        ex(OP_ACC_FILE, 1'h0, 8'h7F);
        @(posedge clk);
        chk(32'(i_mem.fregs[127]), 32'h0000_005A);
        ex(OP_ACC_FILE, 1'h0, 8'h01);
        mchk(16'h0005, 8'h5A);
        ex(OP_ACC_FILE, 1'h0, 8'h00);
        mchk(16'h0000, 8'h5A);
        rd_chk(PTR1, 32'h0000_0005, RESP_OKAY);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_loads();
        t_literals();
        t_stores();
        t_rel();
        t_file();
        close_out();
    end

    // hang guard, far beyond the 120-odd cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
